//--- rtl/clk_standby_ctrl.sv
`timescale 1ns/10ps
module clk_standby_ctrl
  import clk_standby_pkg::*;
(
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            nrst,
  // oscillator edges, synchronous one-cycle pulses
  input  wire logic                            main_osc_input,
  input  wire logic                            sub_osc_input,
  // software controls
  input  wire logic [1:0]                      mode_sel,
  input  wire logic                            sub_osc_enable,
  input  wire logic                            stab_src_sub,
  // processor requests
  input  wire clk_standby_pkg::core_req_type   core_req,
  // status
  output clk_standby_pkg::clk_status_type      status
);
  import clk_standby_pkg::*;

  typedef struct packed {
    pm_state_type st;
    logic [1:0]   mode;
    logic         main_en;
    logic         sub_en;
    logic         phi;
    logic         t12_clr;
    logic [7:0]   tmr1;
    logic [7:0]   tmr2;
  } ctl_state_type;

  ctl_state_type s_r;
  ctl_state_type s_nxt;
  logic          rst_n;
  logic [1:0]    rst_sync_r;
  logic          main_tick_h;
  logic          main_tick_m;
  logic          sub_tick_l;
  logic          lvl_h;
  logic          lvl_m;
  logic          lvl_l;
  logic          stab_main_tick;
  logic          stab_sub_tick;
  logic          main_run;
  logic          sub_run;
  logic          sys_level;
  logic          tmr1_uf;

  // two-flop reset release; assertion stays asynchronous
  // kept apart from s_r so the state struct has a single reset domain
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  assign main_run = s_r.main_en;
  assign sub_run  = s_r.sub_en;

  edge_div #(.HALF(DIV_HIGH_HALF)) u_div_high (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_edge (main_osc_input),
    .run      (main_run),
    .tick     (main_tick_h),
    .level    (lvl_h)
  );
  edge_div #(.HALF(DIV_MIDDLE_HALF)) u_div_middle (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_edge (main_osc_input),
    .run      (main_run),
    .tick     (main_tick_m),
    .level    (lvl_m)
  );
  edge_div #(.HALF(DIV_LOW_HALF)) u_div_low (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_edge (sub_osc_input),
    .run      (sub_run),
    .tick     (sub_tick_l),
    .level    (lvl_l)
  );
  edge_div #(.HALF(DIV_STAB / 2)) u_div_stab_main (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_edge (main_osc_input),
    .run      (main_run),
    .tick     (stab_main_tick),
    .level    ()
  );
  edge_div #(.HALF(DIV_STAB / 2)) u_div_stab_sub (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_edge (sub_osc_input),
    .run      (sub_run),
    .tick     (stab_sub_tick),
    .level    ()
  );

  // selected divider; mode switch safety is left to software
  always_comb
  begin
    case (s_r.mode)
      MODE_HIGH: sys_level = lvl_h;
      MODE_LOW:  sys_level = lvl_l;
      default:   sys_level = lvl_m;
    endcase
  end

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.t12_clr = 1'b0;
    tmr1_uf       = 1'b0;
    case (s_r.st)
      ST_RUN:
      begin
        s_nxt.mode   = mode_sel;
        s_nxt.sub_en = sub_osc_enable;
        s_nxt.phi    = sys_level;
        if (core_req.stop_instruction)
        begin
          s_nxt.st      = ST_STOP;
          s_nxt.phi     = 1'b1;
          s_nxt.main_en = 1'b0;
          s_nxt.sub_en  = 1'b0;
          s_nxt.tmr1    = TMR1_LOAD;
          s_nxt.tmr2    = TMR2_LOAD;
          s_nxt.t12_clr = 1'b1;
        end
        else if (core_req.wait_instruction)
        begin
          s_nxt.st  = ST_WAIT;
          s_nxt.phi = 1'b1;
        end
      end
      ST_STOP:
      begin
        if (core_req.ext_irq)
        begin
          s_nxt.st      = ST_STAB;
          s_nxt.main_en = 1'b1;
          s_nxt.sub_en  = stab_src_sub | sub_osc_enable;
        end
      end
      ST_STAB:
      begin
        // timer 1 on the selected /16 source, its underflow clocks timer 2
        if (stab_src_sub ? stab_sub_tick : stab_main_tick)
        begin
          s_nxt.tmr1 = s_r.tmr1 - 8'h01;
          tmr1_uf    = (s_r.tmr1 == 8'h00);
        end
        if (tmr1_uf)
        begin
          s_nxt.tmr2 = s_r.tmr2 - 8'h01;
          if (s_r.tmr2 == 8'h00)
          begin
            s_nxt.st      = ST_RUN;
            s_nxt.t12_clr = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (core_req.any_irq)
          s_nxt.st = ST_RUN;
      end
      default:
        s_nxt.st = ST_RUN;
    endcase
  end

  // reset restores middle speed with only the main oscillator running
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r.st      <= ST_RUN;
      s_r.mode    <= MODE_MIDDLE;
      s_r.main_en <= 1'b1;
      s_r.sub_en  <= 1'b0;
      s_r.phi     <= 1'b1;
      s_r.t12_clr <= 1'b0;
      s_r.tmr1    <= TMR1_LOAD;
      s_r.tmr2    <= TMR2_LOAD;
    end
    else
    begin
      s_r.st      <= s_nxt.st;
      s_r.mode    <= s_nxt.mode;
      s_r.main_en <= s_nxt.main_en;
      s_r.sub_en  <= s_nxt.sub_en;
      s_r.phi     <= s_nxt.phi;
      s_r.t12_clr <= s_nxt.t12_clr;
      s_r.tmr1    <= s_nxt.tmr1;
      s_r.tmr2    <= s_nxt.tmr2;
    end
  end

  assign status.phi          = s_r.phi;
  assign status.cpu_clk_en   = (s_r.st == ST_RUN);
  assign status.main_osc_en  = s_r.main_en;
  assign status.sub_osc_en   = s_r.sub_en;
  assign status.sub_pins_io  = ~s_r.sub_en;
  assign status.t12_mode_clr = s_r.t12_clr;
  assign status.tmr1         = s_r.tmr1;
  assign status.tmr2         = s_r.tmr2;
endmodule

//--- rtl/clk_standby_pkg.sv
package clk_standby_pkg;

  // speed mode encodings (software selects through mode_sel)
  localparam logic [1:0] MODE_MIDDLE = 2'h0;
  localparam logic [1:0] MODE_HIGH   = 2'h1;
  localparam logic [1:0] MODE_LOW    = 2'h2;

  // dividers
  localparam int unsigned DIV_HIGH_HALF   = 1;
  localparam int unsigned DIV_MIDDLE_HALF = 4;
  localparam int unsigned DIV_LOW_HALF    = 1;
  localparam int unsigned DIV_STAB        = 16;

  // stabilisation timer load values
  localparam logic [7:0] TMR1_LOAD = 8'hff;
  localparam logic [7:0] TMR2_LOAD = 8'h01;
  localparam logic [7:0] T12_MODE_CLEAR = 8'h00;

  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_STOP = 4'h2,
    ST_STAB = 4'h4,
    ST_WAIT = 4'h8
  } pm_state_type;

  typedef struct packed {
    logic stop_instruction;
    logic wait_instruction;
    logic ext_irq;
    logic any_irq;
  } core_req_type;

  typedef struct packed {
    logic       phi;
    logic       cpu_clk_en;
    logic       main_osc_en;
    logic       sub_osc_en;
    logic       sub_pins_io;
    logic       t12_mode_clr;
    logic [7:0] tmr1;
    logic [7:0] tmr2;
  } clk_status_type;

endpackage

//--- rtl/edge_div.sv
`timescale 1ns/10ps
module edge_div #(
  parameter int unsigned HALF = 1
) (
  // clocking
  input  wire logic core_clk,
  input  wire logic rst_n,
  // source
  input  wire logic src_edge,
  input  wire logic run,
  // result
  output logic      tick,
  output logic      level
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       lvl;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    tick  = 1'b0;
    if (!run)
    begin
      s_nxt.cnt = 5'h00;
    end
    else if (src_edge)
    begin
      if (s_r.cnt == 5'(HALF - 1))
      begin
        s_nxt.cnt = 5'h00;
        s_nxt.lvl = ~s_r.lvl;
        tick      = s_r.lvl;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '{cnt: 5'h00, lvl: 1'b1};
    else
      s_r <= s_nxt;
  end

  assign level = s_r.lvl;
endmodule

//--- sim/clk_standby_ctrl_assertions.sv
`timescale 1ns/10ps
module clk_standby_checker
  import clk_standby_pkg::*;
(
  // clock and reset
  input wire logic                            core_clk,
  input wire logic                            nrst,
  // watched ports
  input wire clk_standby_pkg::core_req_type   core_req,
  input wire clk_standby_pkg::clk_status_type status
);
  wire       e = status.cpu_clk_en;
  wire       m = status.main_osc_en;
  wire       p = status.phi;
  wire [7:0] t1 = status.tmr1;
  wire [7:0] t2 = status.tmr2;
  wire       sp = core_req.stop_instruction;
  wire       wt = core_req.wait_instruction && !sp;
  logic      w_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // keeps a wait wake apart from stop recovery
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      w_r <= 1'b0;
    else if (e)
      w_r <= wt;
  end
  stop_in_a: assert property (sp && e |=> !e && p && !m && !status.sub_osc_en && t1 == 8'hff
    && t2 == 8'h01 && status.t12_mode_clr) else $error("bad stop entry");
  wait_in_a: assert property (wt && e |=> !e && p && $stable(m) && $stable(status.sub_osc_en))
    else $error("bad wait entry");
  wait_wake_a: assert property (w_r && !e && core_req.any_irq |=> e)
    else $error("slow wait wake");
  phi_high_a: assert property (!e |-> p)
    else $error("phi not held");
  stop_hold_a: assert property (!e && !m && !core_req.ext_irq |=> !e && !m)
    else $error("stop left");
  ext_wake_a: assert property (!e && !m && core_req.ext_irq |=> m && !e)
    else $error("no restart");
  cascade_a: assert property (!e && !$past(e) && $changed(t2) |-> $past(t1) == 8'h00 && t1 == 8'hff)
    else $error("bad cascade");
  clr_cause_a: assert property (status.t12_mode_clr |-> !e && t1 == 8'hff && t2 == 8'h01 || e && !$past(e))
    else $error("stray clear");
endmodule

bind clk_standby_ctrl clk_standby_checker chk_u (.core_clk, .nrst, .core_req, .status);

//--- sim/core_model.sv
`timescale 1ns/10ps
module core_model
  import clk_standby_pkg::*;
(
  // clock
  input wire logic                            core_clk,
  // stop, wait, ext irq, any irq
  input wire logic [3:0]                      cmd,
  input wire clk_standby_pkg::clk_status_type status,
  // toward the block
  output clk_standby_pkg::core_req_type       core_req,
  output logic                                main_osc_input = 1'b0,
  output logic                                sub_osc_input = 1'b0
);
  logic [2:0] ph_r = 3'h0;
  // timer irqs kept off, no conversion pending
  assign core_req = cmd;
  // oscillators only pulse while enabled, so stop really starves the timers
  always_ff @(posedge core_clk)
  begin
    ph_r <= ph_r == 3'h4 ? 3'h0 : ph_r + 3'h1;
    main_osc_input <= status.main_osc_en;
    sub_osc_input <= status.sub_osc_en && ph_r == 3'h0;
  end
endmodule

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
  import clk_standby_pkg::*;
  logic           core_clk = 1'b0;
  logic           nrst = 1'b0;
  logic [1:0]     mode_sel = 2'h0;
  logic           sub_osc_enable = 1'b0;
  logic           stab_src_sub = 1'b0;
  logic [3:0]     cmd = 4'h0;
  logic           main_osc_input;
  logic           sub_osc_input;
  core_req_type   core_req;
  clk_status_type status;
  int             miscompares = 0;
  int             total_checks = 0;
  wire [3:0]      q = {status.cpu_clk_en, status.main_osc_en, status.sub_osc_en, status.phi};
  clk_standby_ctrl dut_u (.core_clk, .nrst, .main_osc_input, .sub_osc_input, .mode_sel, .sub_osc_enable,
    .stab_src_sub, .core_req, .status);
  core_model core_u (.core_clk, .cmd, .status, .core_req, .main_osc_input, .sub_osc_input);
  initial
    forever #12.5 core_clk = ~core_clk;
  task automatic chk(string n, logic [15:0] s, logic [15:0] x);
    total_checks++;
    if (s !== x)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cy(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(logic [3:0] c);
    @(posedge core_clk);
    cmd <= c;
    @(posedge core_clk);
    cmd <= 4'h0;
    #1;
  endtask
  // first pass only syncs to a phi edge
  task automatic half(output int n);
    logic v;
    repeat (2)
    begin
      v = status.phi;
      n = 0;
      while (status.phi === v && n < 50)
      begin
        cy(1);
        n++;
      end
    end
  endtask
  task automatic t_reset();
    int n;
    @(posedge core_clk);
    nrst <= 1'b0;
    mode_sel <= 2'h0;
    cy(20);
    chk("rst", {q, status.sub_pins_io}, 16'h001b);
    @(posedge core_clk);
    nrst <= 1'b1;
    cy(10);
    half(n);
    chk("mid", n[15:0], 16'h0004);
  endtask
  task automatic t_modes();
    int n;
    for (int k = 1; k < 4; k++)
    begin
      @(posedge core_clk);
      sub_osc_enable <= 1'b1;
      mode_sel <= k[1:0];
      cy(40);
      half(n);
      chk("half", n[15:0], k == 1 ? 16'h0001 : k == 2 ? 16'h0005 : 16'h0004);
    end
  endtask
  task automatic t_stop(logic src, int x);
    int n;
    @(posedge core_clk);
    stab_src_sub <= src;
    pulse(4'h8);
    chk("in", {status.tmr1, status.tmr2[3:0], q[3:2], q[0], status.t12_mode_clr}, 16'hff13);
    cy(20);
    pulse(4'h2);
    for (n = 0; n < 50000 && status.cpu_clk_en !== 1'b1; n++)
      cy(1);
    // first /16 tick may come after 8 or 16 source pulses, so allow half a tick early
    chk("wake", 16'(n >= x - 9 * (x / 8192) && n < x + 100), 16'h0001);
    chk("rel", status.t12_mode_clr, 16'h0001);
  endtask
  task automatic t_wait();
    @(posedge core_clk);
    mode_sel <= 2'h1;
    pulse(4'h4);
    cy(10);
    chk("wait", q, 16'h0007);
    pulse(4'h1);
    chk("run", status.cpu_clk_en, 16'h0001);
  endtask
  initial
  begin
    t_reset();
    t_modes();
    t_stop(1'b0, 8192);
    t_stop(1'b1, 40960);
    t_wait();
    // reset while stopped must restart the main oscillator
    pulse(4'h8);
    t_reset();
    end_of_test();
  end
  initial
  begin
    #2500000;
    miscompares++;
    end_of_test();
  end
endmodule
